// ---- core/lfc_pkg.sv ----
// Shared constants, types and helpers for the loop filter coefficient decoder
`default_nettype none
package lfc_pkg;

  // Field widths
  localparam int PROP_MANT_W  = 16;
  localparam int PROP_SHIFT_W = 6;
  localparam int PROP_FRONT_W = 3;
  localparam int PROP_BACK_W  = 4;
  localparam int INT_MANT_W   = 17;
  localparam int POLE_MANT_W  = 15;
  localparam int EXP_W        = 5;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;

  // Scaling bases and field limits
  localparam int PROP_BASE      = 16;
  localparam int INT_BASE       = 17;
  localparam int POLE_BASE      = 15;
  localparam int PROP_GAIN_MAX  = 22;
  localparam int PROP_SHIFT_MAX = 63;
  localparam int EXP_MAX        = 31;

  // Fixed-point layout of the decoded coefficients
  localparam int PROP_FRAC_W   = PROP_BASE + PROP_SHIFT_MAX;
  localparam int PROP_MAX_SH   = PROP_FRAC_W + PROP_GAIN_MAX - PROP_BASE;
  localparam int PROP_SH_W     = 7;
  localparam int PROP_OUT_W    = 1 + PROP_MANT_W + PROP_MAX_SH;
  localparam int INT_FRAC_W    = INT_BASE + EXP_MAX;
  localparam int INT_OUT_W     = 1 + INT_MANT_W + EXP_MAX;
  localparam int POLE_FRAC_W   = POLE_BASE + EXP_MAX;
  localparam int POLE_OUT_W    = 1 + POLE_MANT_W + EXP_MAX;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_PROP_MANT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PROP_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT1_MANT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT1_EXP  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INT2_MANT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT2_EXP  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_POLE_MANT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_POLE_EXP  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h20;

  // Field positions
  localparam int PROP_SHIFT_LSB = 0;
  localparam int PROP_FRONT_LSB = 8;
  localparam int PROP_BACK_LSB  = 12;
  localparam int ST_GAIN_BIT    = 0;
  localparam int ST_ZERO_BIT    = 1;
  localparam int ST_WCNT_LSB    = 8;
  localparam int WCNT_W         = 8;

  // Reset values
  localparam logic [PROP_MANT_W-1:0]  PROP_MANT_RST  = 16'h0001;
  localparam logic [PROP_SHIFT_W-1:0] PROP_SHIFT_RST = 6'h00;
  localparam logic [PROP_FRONT_W-1:0] PROP_FRONT_RST = 3'h0;
  localparam logic [PROP_BACK_W-1:0]  PROP_BACK_RST  = 4'h0;
  localparam logic [INT_MANT_W-1:0]   INT_MANT_RST   = 17'h00001;
  localparam logic [POLE_MANT_W-1:0]  POLE_MANT_RST  = 15'h0001;
  localparam logic [EXP_W-1:0]        EXP_RST        = 5'h00;

  // Register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lfc_bus_req_t;

  // Proportional coefficient fields
  typedef struct packed {
    logic [PROP_MANT_W-1:0]  mant;
    logic [PROP_SHIFT_W-1:0] shift;
    logic [PROP_FRONT_W-1:0] front;
    logic [PROP_BACK_W-1:0]  back;
  } lfc_prop_t;

  // Total gain, front plus back, capped at its largest legal value
  function automatic logic [4:0] lfc_gain(input logic [PROP_FRONT_W-1:0] front,
                                          input logic [PROP_BACK_W-1:0] back);
    logic [4:0] sum;
    sum = {2'h0, front} + {1'h0, back};
    if (sum > 5'(PROP_GAIN_MAX)) begin
      sum = 5'(PROP_GAIN_MAX);
    end
    return sum;
  endfunction : lfc_gain

  // Left shift that places the proportional mantissa on the fixed-point grid
  function automatic logic [PROP_SH_W-1:0] lfc_prop_shift(input lfc_prop_t p);
    return 7'(PROP_FRAC_W - PROP_BASE) - {1'h0, p.shift} + {2'h0, lfc_gain(p.front, p.back)};
  endfunction : lfc_prop_shift

  // Left shift for an exponent field with base already in the fraction width
  function automatic logic [EXP_W-1:0] lfc_exp_shift(input logic [EXP_W-1:0] e);
    return 5'(EXP_MAX) - e;
  endfunction : lfc_exp_shift

endpackage : lfc_pkg
`default_nettype wire

// ---- core/lfc_scale.sv ----
// Registered mantissa scaler with optional negation
`default_nettype none
module lfc_scale #(
  parameter int MANT_W  = 16,
  parameter int SHIFT_W = 5,
  parameter int OUT_W   = 48,
  parameter bit NEGATE  = 1'b0
) (
  input  wire  logic                     clk_in,    // System clock
  input  wire  logic                     rst_in,    // Async reset, high
  input  wire  logic [MANT_W-1:0]        mant_in,   // Stored magnitude
  input  wire  logic [SHIFT_W-1:0]       shift_in,  // Left shift amount
  output var   logic signed [OUT_W-1:0]  coef_out   // Scaled coefficient
);

  logic        [OUT_W-1:0] mag;
  logic signed [OUT_W-1:0] coef_next;

  // Exact binary shift, then sign
  always_comb begin
    mag       = OUT_W'(mant_in) << shift_in;
    coef_next = NEGATE ? -$signed(mag) : $signed(mag);
  end

  // Output register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      coef_out <= '0;
    end else begin
      coef_out <= coef_next;
    end
  end

endmodule : lfc_scale
`default_nettype wire

// ---- core/lfc_top.sv ----
// Loop filter coefficient decoder: field registers and fixed-point scaling
//
// Decided for this implementation: the address-and-strobe port and the address map.
`default_nettype none
module lfc_top
  import lfc_pkg::*;
(
  input  wire logic                                    CLOCK_IN,       // 20 MHz system clock
  input  wire logic                                    RESET_IN,       // Async reset, high
  input  wire lfc_pkg::lfc_bus_req_t                   BUS_REQ_IN,     // Register request
  output var  logic [lfc_pkg::DATA_W-1:0]              RD_DATA_OUT,    // Read data, one cycle late
  output var  logic signed [lfc_pkg::PROP_OUT_W-1:0]   PROP_COEF_OUT,  // Proportional, 79 fraction bits
  output var  logic signed [lfc_pkg::INT_OUT_W-1:0]    INT1_COEF_OUT,  // First integral, 48 fraction bits
  output var  logic signed [lfc_pkg::INT_OUT_W-1:0]    INT2_COEF_OUT,  // Second integral, 48 fraction bits
  output var  logic signed [lfc_pkg::POLE_OUT_W-1:0]   POLE_COEF_OUT   // Third pole, 46 fraction bits
);

  // Field registers
  lfc_prop_t                 prop_reg;       // Proportional fields
  logic [INT_MANT_W-1:0]     int1_mant_reg;  // First integral magnitude
  logic [EXP_W-1:0]          int1_exp_reg;   // First integral exponent
  logic [INT_MANT_W-1:0]     int2_mant_reg;  // Second integral magnitude
  logic [EXP_W-1:0]          int2_exp_reg;   // Second integral exponent
  logic [POLE_MANT_W-1:0]    pole_mant_reg;  // Third pole mantissa
  logic [EXP_W-1:0]          pole_exp_reg;   // Third pole exponent
  logic [WCNT_W-1:0]         wcnt_reg;       // Accepted write count
  logic [DATA_W-1:0]         rd_data_reg;    // Read data stage

  // Decoded shifts, status and read path
  logic [4:0]                prop_gain;      // Front plus back gain
  logic [PROP_SH_W-1:0]      prop_sh;        // Proportional left shift
  logic [EXP_W-1:0]          int1_sh;        // First integral left shift
  logic [EXP_W-1:0]          int2_sh;        // Second integral left shift
  logic [EXP_W-1:0]          pole_sh;        // Third pole left shift
  logic                      mant_zero;      // Some mantissa is zero
  logic                      wr_mapped;      // Write hits a register
  logic [DATA_W-1:0]         status_word;    // Status register image
  logic [DATA_W-1:0]         rd_data_next;   // Selected read word

  // True when this cycle writes the given register
  function automatic logic wr_hit(input lfc_bus_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : wr_hit

  // True when an address names a writable register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_PROP_MANT) || (a == OFS_PROP_CTRL) ||
           (a == OFS_INT1_MANT) || (a == OFS_INT1_EXP)  ||
           (a == OFS_INT2_MANT) || (a == OFS_INT2_EXP)  ||
           (a == OFS_POLE_MANT) || (a == OFS_POLE_EXP);
  endfunction : addr_mapped

  // Proportional mantissa and control fields
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prop_reg.mant  <= PROP_MANT_RST;
      prop_reg.shift <= PROP_SHIFT_RST;
      prop_reg.front <= PROP_FRONT_RST;
      prop_reg.back  <= PROP_BACK_RST;
    end else begin
      if (wr_hit(BUS_REQ_IN, OFS_PROP_MANT)) begin
        prop_reg.mant <= BUS_REQ_IN.wdata[PROP_MANT_W-1:0];
      end
      if (wr_hit(BUS_REQ_IN, OFS_PROP_CTRL)) begin
        prop_reg.shift <= BUS_REQ_IN.wdata[PROP_SHIFT_LSB +: PROP_SHIFT_W];
        prop_reg.front <= BUS_REQ_IN.wdata[PROP_FRONT_LSB +: PROP_FRONT_W];
        prop_reg.back  <= BUS_REQ_IN.wdata[PROP_BACK_LSB +: PROP_BACK_W];
      end
    end
  end

  // First integral magnitude and exponent
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      int1_mant_reg <= INT_MANT_RST;
      int1_exp_reg  <= EXP_RST;
    end else begin
      if (wr_hit(BUS_REQ_IN, OFS_INT1_MANT)) begin
        int1_mant_reg <= BUS_REQ_IN.wdata[INT_MANT_W-1:0];
      end
      if (wr_hit(BUS_REQ_IN, OFS_INT1_EXP)) begin
        int1_exp_reg <= BUS_REQ_IN.wdata[EXP_W-1:0];
      end
    end
  end

  // Second integral magnitude and exponent
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      int2_mant_reg <= INT_MANT_RST;
      int2_exp_reg  <= EXP_RST;
    end else begin
      if (wr_hit(BUS_REQ_IN, OFS_INT2_MANT)) begin
        int2_mant_reg <= BUS_REQ_IN.wdata[INT_MANT_W-1:0];
      end
      if (wr_hit(BUS_REQ_IN, OFS_INT2_EXP)) begin
        int2_exp_reg <= BUS_REQ_IN.wdata[EXP_W-1:0];
      end
    end
  end

  // Third pole mantissa and exponent
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pole_mant_reg <= POLE_MANT_RST;
      pole_exp_reg  <= EXP_RST;
    end else begin
      if (wr_hit(BUS_REQ_IN, OFS_POLE_MANT)) begin
        pole_mant_reg <= BUS_REQ_IN.wdata[POLE_MANT_W-1:0];
      end
      if (wr_hit(BUS_REQ_IN, OFS_POLE_EXP)) begin
        pole_exp_reg <= BUS_REQ_IN.wdata[EXP_W-1:0];
      end
    end
  end

  // Writes that land in a register are counted, wrapping
  assign wr_mapped = BUS_REQ_IN.wr && addr_mapped(BUS_REQ_IN.addr);
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wcnt_reg <= '0;
    end else if (wr_mapped) begin
      wcnt_reg <= wcnt_reg + WCNT_W'(1);
    end
  end

  always_comb begin
    prop_gain = lfc_gain(prop_reg.front, prop_reg.back);
    prop_sh   = lfc_prop_shift(prop_reg);
  end

  always_comb begin
    int1_sh = lfc_exp_shift(int1_exp_reg);
    int2_sh = lfc_exp_shift(int2_exp_reg);
    pole_sh = lfc_exp_shift(pole_exp_reg);
  end

  // Status word: gain in use, zero mantissa, write count
  always_comb begin
    mant_zero = (prop_reg.mant == '0) || (int1_mant_reg == '0) ||
                (int2_mant_reg == '0) || (pole_mant_reg == '0);
    status_word                        = '0;
    status_word[ST_GAIN_BIT]           = (prop_gain != 5'h00);
    status_word[ST_ZERO_BIT]           = mant_zero;
    status_word[ST_WCNT_LSB +: WCNT_W] = wcnt_reg;
  end

  // Read word selected by address, zero when idle
  always_comb begin
    rd_data_next = '0;
    if (BUS_REQ_IN.rd) begin
      unique case (BUS_REQ_IN.addr)
        OFS_PROP_MANT: rd_data_next = DATA_W'(prop_reg.mant);
        OFS_PROP_CTRL: begin
          rd_data_next[PROP_SHIFT_LSB +: PROP_SHIFT_W] = prop_reg.shift;
          rd_data_next[PROP_FRONT_LSB +: PROP_FRONT_W] = prop_reg.front;
          rd_data_next[PROP_BACK_LSB +: PROP_BACK_W]   = prop_reg.back;
        end
        OFS_INT1_MANT: rd_data_next = DATA_W'(int1_mant_reg);
        OFS_INT1_EXP:  rd_data_next = DATA_W'(int1_exp_reg);
        OFS_INT2_MANT: rd_data_next = DATA_W'(int2_mant_reg);
        OFS_INT2_EXP:  rd_data_next = DATA_W'(int2_exp_reg);
        OFS_POLE_MANT: rd_data_next = DATA_W'(pole_mant_reg);
        OFS_POLE_EXP:  rd_data_next = DATA_W'(pole_exp_reg);
        OFS_STATUS:    rd_data_next = status_word;
        default:       rd_data_next = '0;
      endcase
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end
  assign RD_DATA_OUT = rd_data_reg;

  lfc_scale #(
    .MANT_W  (PROP_MANT_W),
    .SHIFT_W (PROP_SH_W),
    .OUT_W   (PROP_OUT_W),
    .NEGATE  (1'b0)
  ) u_prop (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .mant_in  (prop_reg.mant),
    .shift_in (prop_sh),
    .coef_out (PROP_COEF_OUT)
  );

  lfc_scale #(
    .MANT_W  (INT_MANT_W),
    .SHIFT_W (EXP_W),
    .OUT_W   (INT_OUT_W),
    .NEGATE  (1'b1)
  ) u_int1 (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .mant_in  (int1_mant_reg),
    .shift_in (int1_sh),
    .coef_out (INT1_COEF_OUT)
  );

  lfc_scale #(
    .MANT_W  (INT_MANT_W),
    .SHIFT_W (EXP_W),
    .OUT_W   (INT_OUT_W),
    .NEGATE  (1'b1)
  ) u_int2 (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .mant_in  (int2_mant_reg),
    .shift_in (int2_sh),
    .coef_out (INT2_COEF_OUT)
  );

  lfc_scale #(
    .MANT_W  (POLE_MANT_W),
    .SHIFT_W (EXP_W),
    .OUT_W   (POLE_OUT_W),
    .NEGATE  (1'b0)
  ) u_pole (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .mant_in  (pole_mant_reg),
    .shift_in (pole_sh),
    .coef_out (POLE_COEF_OUT)
  );

  prop_scale_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> PROP_COEF_OUT == $signed(PROP_OUT_W'($past(prop_reg.mant)) << $past(prop_sh)))
    else $error("Proportional coefficient decode mismatch");

  prop_point_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    8'(prop_sh) + 8'(prop_reg.shift) == 8'(PROP_FRAC_W - PROP_BASE) + 8'(prop_gain))
    else $error("Proportional shift does not follow shift field");

  int1_scale_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> -INT1_COEF_OUT == $signed(INT_OUT_W'($past(int1_mant_reg)) << (5'(EXP_MAX) - $past(int1_exp_reg))))
    else $error("First integral coefficient decode mismatch");

  int_sign_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) && $past(int1_mant_reg) != '0 && $past(int2_mant_reg) != '0 |-> INT1_COEF_OUT < 0 && INT2_COEF_OUT < 0)
    else $error("Integral coefficient is not negative");

  int2_scale_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> -INT2_COEF_OUT == $signed(INT_OUT_W'($past(int2_mant_reg)) << (5'(EXP_MAX) - $past(int2_exp_reg))))
    else $error("Second integral coefficient decode mismatch");

  pole_scale_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> POLE_COEF_OUT == $signed(POLE_OUT_W'($past(pole_mant_reg)) << (5'(EXP_MAX) - $past(pole_exp_reg))))
    else $error("Third pole coefficient decode mismatch");

  pole_sign_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) && $past(pole_mant_reg) != '0 |-> POLE_COEF_OUT > 0)
    else $error("Third pole coefficient is not positive");

  exact_back_a: assert property (
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> (PROP_COEF_OUT >>> $past(prop_sh)) == $signed(PROP_OUT_W'($past(prop_reg.mant))))
    else $error("Proportional coefficient lost mantissa bits");

endmodule : lfc_top
`default_nettype wire

// ---- tb/lfc_top_tb.sv ----
// Self-checking bench for the loop filter coefficient decoder
`default_nettype none
module lfc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lfc_pkg::*;
  typedef struct packed {
    logic [15:0] pm; logic [5:0] sh; logic [2:0] fr; logic [3:0] bk;
    logic [16:0] am; logic [4:0] ae; logic [16:0] bm; logic [4:0] be; logic [14:0] qm; logic [4:0] qe;
  } lfc_row_t;
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  lfc_bus_req_t                  req = '0;
  logic [DATA_W-1:0]             rdata;
  logic signed [PROP_OUT_W-1:0]  prop;
  logic signed [INT_OUT_W-1:0]   int1, int2;
  logic signed [POLE_OUT_W-1:0]  pole;
  int                            err_count = 0;
  int                            comparisons = 0;
  // Example, largest and smallest legal loads
  // Shift field in range
  lfc_row_t rows [3] = '{
    '{16'hD0A8, 6'h06, 3'h0, 4'h0, 17'h1250B, 5'h0D, 17'h13ABB, 5'h0D, 15'h420A, 5'h08},
    '{16'hFFFF, 6'h00, 3'h7, 4'hF, 17'h1FFFF, 5'h00, 17'h00001, 5'h1F, 15'h7FFF, 5'h1F},
    '{16'h0001, 6'h3F, 3'h0, 4'h0, 17'h00001, 5'h1F, 17'h1FFFF, 5'h00, 15'h0001, 5'h00}};
  lfc_row_t rrow = '{16'h0001, 6'h00, 3'h0, 4'h0, 17'h00001, 5'h00, 17'h00001, 5'h00, 15'h0001, 5'h00};
  // Clock, 50 ns period
  always #25 clk = ~clk;
  lfc_top dut (.CLOCK_IN(clk), .RESET_IN(rst), .BUS_REQ_IN(req),
    .RD_DATA_OUT(rdata), .PROP_COEF_OUT(prop), .INT1_COEF_OUT(int1), .INT2_COEF_OUT(int2), .POLE_COEF_OUT(pole));
  // Compare and count
  task automatic check(input logic signed [127:0] seen, input logic signed [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Mantissa on the fixed-point grid, optionally negated
  function automatic logic signed [127:0] sc(input logic [16:0] m, input int s, input bit n);
    logic signed [127:0] v;
    v = 128'(m) <<< s;
    return n ? -v : v;
  endfunction : sc
  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask : wr
  // One-cycle read strobe, data checked in the cycle after it
  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    check(rdata, e);
  endtask : rd_check
  task automatic load(input lfc_row_t r);
    wr(OFS_PROP_MANT, 32'(r.pm));
    wr(OFS_PROP_CTRL, {16'h0000, r.bk, 1'b0, r.fr, 2'h0, r.sh});
    wr(OFS_INT1_MANT, 32'(r.am));
    wr(OFS_INT1_EXP, 32'(r.ae));
    wr(OFS_INT2_MANT, 32'(r.bm));
    wr(OFS_INT2_EXP, 32'(r.be));
    wr(OFS_POLE_MANT, 32'(r.qm));
    wr(OFS_POLE_EXP, 32'(r.qe));
    @(posedge clk);
    req <= '0;
  endtask : load
  // Bounded wait for the decoded values, then compare
  task automatic expect_row(input lfc_row_t r);
    logic signed [127:0] ep, e1, e2, eq;
    ep = sc(17'(r.pm), 63 - int'(r.sh) + int'(r.fr) + int'(r.bk), 1'b0);
    e1 = sc(r.am, 31 - int'(r.ae), 1'b1);
    e2 = sc(r.bm, 31 - int'(r.be), 1'b1);
    eq = sc(17'(r.qm), 31 - int'(r.qe), 1'b0);
    for (int i = 0; i < 8 && !(prop === ep && int1 === e1 && int2 === e2 && pole === eq); i++) begin
      @(posedge clk);
      #1;
    end
    check(prop, ep);
    check(int1, e1);
    check(int2, e2);
    check(pole, eq);
  endtask : expect_row
  task automatic test_done();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Reset, table rows, unmapped write, readback, mid-run reset
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    expect_row(rrow);
    foreach (rows[i]) begin
      load(rows[i]);
      expect_row(rows[i]);
    end
    // Unmapped write must leave every field alone
    wr(8'h24, 32'hFFFFFFFF);
    rd_check(OFS_INT1_MANT, 32'(rows[2].am));
    rd_check(OFS_PROP_CTRL, {16'h0000, rows[2].bk, 1'b0, rows[2].fr, 2'h0, rows[2].sh});
    rd_check(OFS_STATUS, 32'h00001800);
    expect_row(rows[2]);
    // Zero mantissa and nonzero gain show in status
    wr(OFS_PROP_MANT, 32'h00000000);
    wr(OFS_PROP_CTRL, 32'h00000100);
    rd_check(OFS_STATUS, 32'h00001A03);
    check(prop, 128'sh0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    expect_row(rrow);
    rd_check(OFS_STATUS, 32'h00000000);
    test_done();
  end
endmodule : lfc_top_tb
`default_nettype wire
